// [mpf_monitor.sv]
// monitor, peak hold, averaging and fault record logic with bus slave
//
// Overview of operation
// - in band, step dac one lsb per period
// - trim divider zero stops all trimming
// - trim divider resets to ten
// - fault checks paced by monitor divider
// - monitor divider zero stops all but bus-error checks
// - monitor divider resets to fifty
// - voltage peak tracks largest, averaged if enabled
// - voltage/current peak: zero clears, else baseline
// - current peak holds maximum, zero after reset
// - heat peak: all ones resets to lowest
// - upper config byte sets sample spacing
// - lower config byte gives log2 sample count
// - nonzero count averages voltage for limit checks
// - zero count ignores spacing byte entirely
// - bus commands ignored while averaging runs
// - fault sets its flag and alert pin
// - flag bits 15, 7, 3 read zero
// - negative current sets flag bit 11
// - bit 2 is or of bits 14, 13
// - bit 0 set by non-heat upper bits
// - clearing actions zero all flags but those set that cycle
// - flags read only, restore leaves them
// - store-peak bit saves peaks on any fault
// - response 01 shuts down, 10 does too, no retry
`timescale 1ns/1ps
module mpf_monitor
  import mpf_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] vout_sample,
  input wire logic [15:0] iout_sample,
  input wire logic [15:0] temp_sample,
  input wire logic [15:0] vout_high_fault_limit,
  input wire logic [15:0] vout_high_warning_limit,
  input wire logic [15:0] vout_low_warning_limit,
  input wire logic [15:0] vout_low_fault_limit,
  input wire logic output_overcurrent_warning,
  input wire logic output_overcurrent_fault,
  input wire logic negative_current_fault,
  input wire logic overheat_warning,
  input wire logic overheat_fault,
  input wire logic in_regulation_band,
  input wire logic trim_raise,
  input wire logic supply_on_request,
  input wire logic clear_faults,
  input wire logic restore_defaults,
  output logic [11:0] reference_dac_output,
  output logic supply_enable_output,
  output logic fault_alert_pin_out,
  output logic fault_alert_pin_oe,
  output logic peak_store_req
);

  // ---------------- pin synchronisers and bus edges
  logic [1:0] scl_sync_q, sda_sync_q;
  logic scl_prev_q, sda_prev_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end
  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire bus_start = scl_s & scl_prev_q & ~sda_s & sda_prev_q;
  wire bus_stop = scl_s & scl_prev_q & sda_s & ~sda_prev_q;

  // ---------------- registers and shared state
  logic [15:0] trim_div_q, mon_div_q, vpeak_q, ipeak_q, hpeak_q;
  logic [15:0] avg_cfg_q, act_cfg_q, flag_q, alarm_rd;
  logic shutdown_q;
  mpf_avg_st_t avg_st_q;
  // only a running sample sequence holds off the bus
  wire avg_busy = (avg_st_q == MPF_A_RUN);

  // ---------------- serial bus slave
  mpf_bus_st_t bus_st_q;
  logic [7:0] shreg_q, cmd_q, wlo_q, whi_q, tx_q;
  logic [3:0] bits_q;
  logic [1:0] nbytes_q;
  logic rw_q, sda_low_q, byte_sel_q, acked_q;
  logic [15:0] rd_word;
  logic rd_hit;
  wire addr_match = (shreg_q[7:1] == DEV_ADDR);
  wire accept_addr = addr_match & ~avg_busy;
  wire commit = bus_stop & ~rw_q & (nbytes_q == 2'h2) & ~avg_busy;

  // read data selection by command code
  always_comb begin
    rd_hit = 1'b1;
    case (cmd_q)
      CMD_TRIM_STEP_RATE_DIV: rd_word = trim_div_q;
      CMD_MONITOR_RATE_DIV: rd_word = mon_div_q;
      CMD_MAX_VOLTAGE_SEEN: rd_word = vpeak_q;
      CMD_MAX_CURRENT_SEEN: rd_word = ipeak_q;
      CMD_MAX_HEAT_SEEN: rd_word = hpeak_q;
      CMD_AVERAGING_CONFIG: rd_word = avg_cfg_q;
      CMD_ALARM_FLAGS: rd_word = alarm_rd;
      CMD_ALARM_ACTION_CONFIG: rd_word = act_cfg_q;
      default: begin
        rd_word = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // byte-level slave: shift on rising scl, drive on falling scl
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus_st_q <= MPF_B_IDLE;
      shreg_q <= 8'h00;
      cmd_q <= 8'h00;
      wlo_q <= 8'h00;
      whi_q <= 8'h00;
      tx_q <= 8'h00;
      bits_q <= 4'h0;
      nbytes_q <= 2'h0;
      rw_q <= 1'b0;
      sda_low_q <= 1'b0;
      byte_sel_q <= 1'b0;
      acked_q <= 1'b0;
    end else if (bus_start) begin
      bus_st_q <= MPF_B_ADDR;
      bits_q <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (bus_stop) begin
      bus_st_q <= MPF_B_IDLE;
      sda_low_q <= 1'b0;
      nbytes_q <= 2'h0;
      rw_q <= 1'b0;
    end else begin
      case (bus_st_q)
        MPF_B_ADDR, MPF_B_CMD, MPF_B_WDAT: begin
          if (scl_rise) begin
            shreg_q <= {shreg_q[6:0], sda_s};
            bits_q <= bits_q + 4'h1;
          end else if (scl_fall && bits_q == 4'h8) begin
            sda_low_q <= 1'b1;
            if (bus_st_q == MPF_B_ADDR) begin
              rw_q <= shreg_q[0];
              bus_st_q <= accept_addr ? MPF_B_AACK : MPF_B_IDLE;
              sda_low_q <= accept_addr;
            end else if (bus_st_q == MPF_B_CMD) begin
              cmd_q <= shreg_q;
              nbytes_q <= 2'h0;
              bus_st_q <= MPF_B_CACK;
            end else begin
              if (nbytes_q == 2'h0) wlo_q <= shreg_q;
              else whi_q <= shreg_q;
              if (nbytes_q != 2'h3) nbytes_q <= nbytes_q + 2'h1;
              bus_st_q <= MPF_B_WACK;
            end
          end
        end
        MPF_B_AACK: begin
          if (scl_fall) begin
            bits_q <= 4'h0;
            if (rw_q) begin
              tx_q <= rd_word[7:0];
              byte_sel_q <= 1'b1;
              sda_low_q <= ~rd_word[7];
              bus_st_q <= MPF_B_RDAT;
            end else begin
              sda_low_q <= 1'b0;
              bus_st_q <= MPF_B_CMD;
            end
          end
        end
        MPF_B_CACK, MPF_B_WACK: begin
          if (scl_fall) begin
            sda_low_q <= 1'b0;
            bits_q <= 4'h0;
            bus_st_q <= MPF_B_WDAT;
          end
        end
        MPF_B_RDAT: begin
          if (scl_rise) begin
            bits_q <= bits_q + 4'h1;
          end else if (scl_fall) begin
            if (bits_q == 4'h8) begin
              sda_low_q <= 1'b0;
              bus_st_q <= MPF_B_RACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_low_q <= ~tx_q[6];
            end
          end
        end
        MPF_B_RACK: begin
          if (scl_rise) begin
            acked_q <= ~sda_s;
          end else if (scl_fall) begin
            bits_q <= 4'h0;
            if (acked_q) begin
              tx_q <= byte_sel_q ? rd_word[15:8] : rd_word[7:0];
              sda_low_q <= byte_sel_q ? ~rd_word[15] : ~rd_word[7];
              byte_sel_q <= ~byte_sel_q;
              bus_st_q <= MPF_B_RDAT;
            end else begin
              bus_st_q <= MPF_B_IDLE;
            end
          end
        end
        default: bus_st_q <= MPF_B_IDLE;
      endcase
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = sda_low_q;

  // write decode
  wire [15:0] wword = {whi_q, wlo_q};
  wire wr_trim = commit & (cmd_q == CMD_TRIM_STEP_RATE_DIV);
  wire wr_mon = commit & (cmd_q == CMD_MONITOR_RATE_DIV);
  wire wr_vpk = commit & (cmd_q == CMD_MAX_VOLTAGE_SEEN);
  wire wr_ipk = commit & (cmd_q == CMD_MAX_CURRENT_SEEN);
  wire wr_hpk = commit & (cmd_q == CMD_MAX_HEAT_SEEN);
  wire wr_avg = commit & (cmd_q == CMD_AVERAGING_CONFIG);
  wire wr_act = commit & (cmd_q == CMD_ALARM_ACTION_CONFIG);
  wire rd_miss = scl_fall & (bus_st_q == MPF_B_AACK) & rw_q & ~rd_hit;
  wire wr_bad = commit & (cmd_q == CMD_ALARM_FLAGS
    || !(wr_trim | wr_mon | wr_vpk | wr_ipk | wr_hpk | wr_avg | wr_act));

  // configuration registers, restore returns them to defaults
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      trim_div_q <= RST_TRIM_STEP_RATE_DIV;
      mon_div_q <= RST_MONITOR_RATE_DIV;
      avg_cfg_q <= RST_AVERAGING_CONFIG;
      act_cfg_q <= RST_ALARM_ACTION_CONFIG;
    end else if (restore_defaults) begin
      trim_div_q <= RST_TRIM_STEP_RATE_DIV;
      mon_div_q <= RST_MONITOR_RATE_DIV;
      avg_cfg_q <= RST_AVERAGING_CONFIG;
      act_cfg_q <= RST_ALARM_ACTION_CONFIG;
    end else begin
      if (wr_trim) trim_div_q <= wword;
      if (wr_mon) mon_div_q <= wword;
      if (wr_avg) avg_cfg_q <= wword;
      if (wr_act) act_cfg_q <= wword & ACT_WRITE_MASK;
    end
  end

  // ---------------- 10 kHz base tick and the two rate dividers
  logic [11:0] tick_cnt_q;
  wire base_tick = (tick_cnt_q == 12'(TICK_CYCLES - 1));
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) tick_cnt_q <= 12'h000;
    else tick_cnt_q <= base_tick ? 12'h000 : tick_cnt_q + 12'h001;
  end

  wire [15:0] div_val [2];
  wire [1:0] div_pulse;
  assign div_val[0] = trim_div_q;
  assign div_val[1] = mon_div_q;
  // zero divider keeps the counter cleared and never fires
  for (genvar g = 0; g < 2; g++) begin : g_rate
    logic [15:0] cnt_q;
    wire fire = base_tick & (div_val[g] != 16'h0000)
      & (cnt_q + 16'h0001 >= div_val[g]);
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) cnt_q <= 16'h0000;
      else if (div_val[g] == 16'h0000 || fire) cnt_q <= 16'h0000;
      else if (base_tick) cnt_q <= cnt_q + 16'h0001;
    end
    assign div_pulse[g] = fire;
  end
  wire mon_strobe = div_pulse[1];
  wire dac_step = div_pulse[0] & in_regulation_band;

  // in-band trim, one lsb per step, saturating
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) reference_dac_output <= RST_DAC;
    else if (dac_step && trim_raise && reference_dac_output != 12'hfff)
      reference_dac_output <= reference_dac_output + 12'h001;
    else if (dac_step && !trim_raise && reference_dac_output != 12'h000)
      reference_dac_output <= reference_dac_output - 12'h001;
  end

  // ---------------- averaging sequencer
  wire [7:0] log2_raw = avg_cfg_q[7:0];
  wire [3:0] log2_n = (log2_raw > 8'(AVG_LOG2_MAX)) ? 4'(AVG_LOG2_MAX)
    : log2_raw[3:0];
  wire [8:0] n_samples = 9'h001 << log2_n;
  wire [15:0] spacing_ns = 16'(SAMPLE_DELAY_BASE_NS)
    + 16'(avg_cfg_q[15:8]) * 16'(SAMPLE_DELAY_STEP_NS);
  logic [23:0] sum_q;
  logic [8:0] taken_q;
  logic [15:0] ns_q, vavg_q;
  wire space_ok = (ns_q >= spacing_ns);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      avg_st_q <= MPF_A_IDLE;
      sum_q <= 24'h000000;
      taken_q <= 9'h000;
      ns_q <= 16'h0000;
      vavg_q <= 16'h0000;
    end else begin
      case (avg_st_q)
        MPF_A_IDLE: begin
          if (mon_strobe && log2_raw == 8'h00) begin
            vavg_q <= vout_sample;
            avg_st_q <= MPF_A_EVAL;
          end else if (mon_strobe) begin
            sum_q <= {8'h00, vout_sample};
            taken_q <= 9'h001;
            ns_q <= 16'(CLK_PERIOD_NS);
            avg_st_q <= MPF_A_RUN;
          end
        end
        MPF_A_RUN: begin
          if (taken_q == n_samples) begin
            vavg_q <= 16'(sum_q >> log2_n);
            avg_st_q <= MPF_A_EVAL;
          end else if (space_ok) begin
            sum_q <= sum_q + {8'h00, vout_sample};
            taken_q <= taken_q + 9'h001;
            ns_q <= 16'(CLK_PERIOD_NS);
          end else begin
            ns_q <= ns_q + 16'(CLK_PERIOD_NS);
          end
        end
        MPF_A_EVAL: avg_st_q <= MPF_A_IDLE;
        default: avg_st_q <= MPF_A_IDLE;
      endcase
    end
  end
  wire mon_eval = (avg_st_q == MPF_A_EVAL);

  // ---------------- fault events and sticky flags
  logic [15:0] ev;
  always_comb begin
    ev = 16'h0000;
    ev[BIT_OVERHEAT_WARNING] = mon_eval & overheat_warning;
    ev[BIT_OVERHEAT_FAULT] = mon_eval & overheat_fault;
    ev[BIT_OC_WARNING] = mon_eval & output_overcurrent_warning;
    ev[BIT_NEG_CURRENT_FAULT] = mon_eval & negative_current_fault;
    ev[BIT_LOW_V_WARNING] = mon_eval & (vavg_q < vout_low_warning_limit);
    ev[BIT_LOW_V_FAULT] = mon_eval & (vavg_q < vout_low_fault_limit);
    ev[BIT_HIGH_V_WARNING] = mon_eval & (vavg_q > vout_high_warning_limit);
    ev[BIT_HIGH_V_FAULT] = mon_eval & (vavg_q > vout_high_fault_limit);
    ev[BIT_OC_FAULT] = mon_eval & output_overcurrent_fault;
    ev[BIT_COMMS_MEMORY] = wr_bad | rd_miss;
  end
  // set wins over clear; restore never touches flags
  wire [15:0] flag_d;
  for (genvar b = 0; b < 16; b++) begin : g_flag
    if (STICKY_MASK[b]) begin : g_sticky
      assign flag_d[b] = ev[b] | (flag_q[b] & ~clear_faults);
    end else begin : g_none
      assign flag_d[b] = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) flag_q <= 16'h0000;
    else flag_q <= flag_d;
  end

  // read view with summaries
  always_comb begin
    alarm_rd = flag_q;
    alarm_rd[BIT_SUPPLY_OFF] = ~supply_enable_output;
    alarm_rd[BIT_HEAT_SUMMARY] = flag_q[BIT_OVERHEAT_WARNING]
      | flag_q[BIT_OVERHEAT_FAULT];
    alarm_rd[BIT_OTHER_SUMMARY] = |(flag_q & OTHER_SRC_MASK);
  end
  assign fault_alert_pin_out = 1'b0;
  assign fault_alert_pin_oe = |(flag_q & STICKY_MASK);

  // fault actions: shutdown latch and peak store request
  wire [1:0] r_hv = act_cfg_q[ACT_HIGH_V_LSB +: 2];
  wire [1:0] r_lv = act_cfg_q[ACT_LOW_V_LSB +: 2];
  wire [1:0] r_oc = act_cfg_q[ACT_OC_LSB +: 2];
  wire [1:0] r_ht = act_cfg_q[ACT_HEAT_LSB +: 2];
  wire [1:0] r_ni = act_cfg_q[ACT_NEG_I_LSB +: 2];
  wire [4:0] fault_ev = {ev[BIT_HIGH_V_FAULT], ev[BIT_LOW_V_FAULT],
    ev[BIT_OC_FAULT], ev[BIT_OVERHEAT_FAULT], ev[BIT_NEG_CURRENT_FAULT]};
  wire [4:0] fault_off = {r_hv == RESP_SHUTDOWN || r_hv == RESP_RETRY,
    r_lv == RESP_SHUTDOWN || r_lv == RESP_RETRY,
    r_oc == RESP_SHUTDOWN || r_oc == RESP_RETRY,
    r_ht == RESP_SHUTDOWN || r_ht == RESP_RETRY,
    r_ni == RESP_SHUTDOWN || r_ni == RESP_RETRY};
  wire fault_any = |fault_ev;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shutdown_q <= 1'b0;
      peak_store_req <= 1'b0;
    end else begin
      shutdown_q <= (|(fault_ev & fault_off))
        | (shutdown_q & ~clear_faults);
      peak_store_req <= fault_any & act_cfg_q[ACT_STORE_PEAK_BIT];
    end
  end
  assign supply_enable_output = supply_on_request & ~shutdown_q;

  // ---------------- peak hold, bus writes win over updates
  wire heat_above = $signed(temp_sample) > $signed(hpeak_q);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vpeak_q <= RST_PEAK;
      ipeak_q <= RST_PEAK;
      hpeak_q <= RST_PEAK;
    end else begin
      if (wr_vpk) vpeak_q <= wword;
      else if (mon_eval && vavg_q > vpeak_q) vpeak_q <= vavg_q;
      if (wr_ipk) ipeak_q <= wword;
      else if (mon_eval && iout_sample > ipeak_q)
        ipeak_q <= iout_sample;
      if (wr_hpk)
        hpeak_q <= (wword == HEAT_PEAK_CLEAR_CODE) ? HEAT_LOWEST
          : wword;
      else if (mon_eval && heat_above) hpeak_q <= temp_sample;
    end
  end

  // ---------------- assertions
  AST_TRIM_OFF: assert property (@(posedge clock) disable iff (!reset_n)
    trim_div_q == 16'h0000 |-> !dac_step)
    else $error("dac stepped with zero trim divider");
  AST_MON_OFF: assert property (@(posedge clock) disable iff (!reset_n)
    mon_div_q == 16'h0000 |-> !mon_strobe)
    else $error("monitor fired with zero divider");
  AST_DEFAULTS: assert property (@(posedge clock) disable iff (!reset_n)
    restore_defaults |=> trim_div_q == RST_TRIM_STEP_RATE_DIV
      && mon_div_q == RST_MONITOR_RATE_DIV)
    else $error("rate dividers not at defaults");
  AST_DAC_ONE_LSB: assert property (@(posedge clock) disable iff (!reset_n)
    (reference_dac_output != $past(reference_dac_output)) |->
      $past(dac_step) && (reference_dac_output - $past(reference_dac_output)
      == 12'h001 || $past(reference_dac_output) - reference_dac_output
      == 12'h001))
    else $error("dac moved without a single lsb step");
  AST_RESERVED: assert property (@(posedge clock) disable iff (!reset_n)
    !alarm_rd[15] && !alarm_rd[7] && !alarm_rd[3])
    else $error("reserved flag bit set");
  AST_HEAT_SUM: assert property (@(posedge clock) disable iff (!reset_n)
    alarm_rd[2] == (alarm_rd[14] | alarm_rd[13]))
    else $error("heat summary wrong");
  AST_OTHER_SUM: assert property (@(posedge clock) disable iff (!reset_n)
    alarm_rd[0] == |alarm_rd[12:8])
    else $error("other summary wrong");
  sequence s_neg_seen;
    mon_eval && negative_current_fault;
  endsequence
  AST_NEG_I: assert property (@(posedge clock) disable iff (!reset_n)
    s_neg_seen |=> flag_q[11] && fault_alert_pin_oe)
    else $error("negative current not flagged");
  AST_STORE: assert property (@(posedge clock) disable iff (!reset_n)
    fault_any && act_cfg_q[15] |=> peak_store_req)
    else $error("peak store not requested");
  AST_BUSY_NACK: assert property (@(posedge clock) disable iff (!reset_n)
    bus_st_q == MPF_B_ADDR && scl_fall && bits_q == 4'h8 && avg_busy
      && !bus_start && !bus_stop |=> bus_st_q == MPF_B_IDLE)
    else $error("address accepted while averaging");
  AST_CLEAR: assert property (@(posedge clock) disable iff (!reset_n)
    clear_faults && ev == 16'h0000 |=> flag_q == 16'h0000)
    else $error("flags survived a clear");

endmodule : mpf_monitor

// [mpf_pkg.sv]
// constants, offsets and types for the monitor, peak and fault block
package mpf_pkg;

  // timing base
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned BASE_TICK_HZ = 10_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / BASE_TICK_HZ;
  localparam int unsigned SAMPLE_DELAY_BASE_NS = 1750;
  localparam int unsigned SAMPLE_DELAY_STEP_NS = 250;
  localparam int unsigned AVG_LOG2_MAX = 8;

  // command codes of the registers
  localparam logic [7:0] CMD_TRIM_STEP_RATE_DIV = 8'hd2;
  localparam logic [7:0] CMD_MONITOR_RATE_DIV = 8'hd3;
  localparam logic [7:0] CMD_MAX_VOLTAGE_SEEN = 8'hd4;
  localparam logic [7:0] CMD_MAX_CURRENT_SEEN = 8'hd5;
  localparam logic [7:0] CMD_MAX_HEAT_SEEN = 8'hd6;
  localparam logic [7:0] CMD_AVERAGING_CONFIG = 8'hd7;
  localparam logic [7:0] CMD_ALARM_FLAGS = 8'hd8;
  localparam logic [7:0] CMD_ALARM_ACTION_CONFIG = 8'hd9;

  // values after reset
  localparam logic [15:0] RST_TRIM_STEP_RATE_DIV = 16'h000a;
  localparam logic [15:0] RST_MONITOR_RATE_DIV = 16'h0032;
  localparam logic [15:0] RST_PEAK = 16'h0000;
  localparam logic [15:0] RST_AVERAGING_CONFIG = 16'h0000;
  localparam logic [15:0] RST_ALARM_ACTION_CONFIG = 16'h0000;
  localparam logic [15:0] HEAT_PEAK_CLEAR_CODE = 16'hffff;
  localparam logic [15:0] HEAT_LOWEST = 16'h8000;
  localparam logic [11:0] RST_DAC = 12'h800;

  // alarm_flags bit positions
  localparam int unsigned BIT_OVERHEAT_WARNING = 14;
  localparam int unsigned BIT_OVERHEAT_FAULT = 13;
  localparam int unsigned BIT_OC_WARNING = 12;
  localparam int unsigned BIT_NEG_CURRENT_FAULT = 11;
  localparam int unsigned BIT_LOW_V_WARNING = 10;
  localparam int unsigned BIT_LOW_V_FAULT = 9;
  localparam int unsigned BIT_HIGH_V_WARNING = 8;
  localparam int unsigned BIT_SUPPLY_OFF = 6;
  localparam int unsigned BIT_HIGH_V_FAULT = 5;
  localparam int unsigned BIT_OC_FAULT = 4;
  localparam int unsigned BIT_HEAT_SUMMARY = 2;
  localparam int unsigned BIT_COMMS_MEMORY = 1;
  localparam int unsigned BIT_OTHER_SUMMARY = 0;
  localparam logic [15:0] STICKY_MASK = 16'h7f32;
  localparam logic [15:0] OTHER_SRC_MASK = 16'h1f00;

  // alarm_action_config field positions
  localparam int unsigned ACT_HIGH_V_LSB = 0;
  localparam int unsigned ACT_LOW_V_LSB = 2;
  localparam int unsigned ACT_OC_LSB = 4;
  localparam int unsigned ACT_HEAT_LSB = 6;
  localparam int unsigned ACT_NEG_I_LSB = 8;
  localparam int unsigned ACT_STORE_PEAK_BIT = 15;
  localparam logic [15:0] ACT_WRITE_MASK = 16'h83ff;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;

  // serial bus controller states
  typedef enum logic [8:0] {
    MPF_B_IDLE = 9'h001,
    MPF_B_ADDR = 9'h002,
    MPF_B_AACK = 9'h004,
    MPF_B_CMD  = 9'h008,
    MPF_B_CACK = 9'h010,
    MPF_B_WDAT = 9'h020,
    MPF_B_WACK = 9'h040,
    MPF_B_RDAT = 9'h080,
    MPF_B_RACK = 9'h100
  } mpf_bus_st_t;

  // averaging sequencer states
  typedef enum logic [2:0] {
    MPF_A_IDLE = 3'h1,
    MPF_A_RUN  = 3'h2,
    MPF_A_EVAL = 3'h4
  } mpf_avg_st_t;

endpackage : mpf_pkg

// [mpf_host.sv]
// host model driving the serial management bus
`timescale 1ns/1ps
module mpf_host #(
  parameter logic [6:0] ADDR = 7'h20
) (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // start: data falls while clock high
  task automatic go;
    scl = 1'b0;
    #40 sda_low = 1'b0;
    #120 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80;
  endtask : go
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      scl = 1'b0;
      #40 sda_low = !d[i];
      #120 scl = 1'b1;
      #80 q[i] = sda;
      #80;
    end
  endtask : xfer
  // stop, then the line is left to its pull-up
  task automatic stop;
    scl = 1'b0;
    #40 sda_low = 1'b1;
    #120 scl = 1'b1;
    #160 sda_low = 1'b0;
    #160;
  endtask : stop
  // word write, low byte first
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    logic [8:0] q;
    go;
    xfer({ADDR, 2'b01}, q);
    xfer({c, 1'b1}, q);
    xfer({v[7:0], 1'b1}, q);
    xfer({v[15:8], 1'b1}, q);
    stop;
  endtask : wr
  // word read; low byte acked, high byte refused
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    logic [8:0] q;
    go;
    xfer({ADDR, 2'b01}, q);
    xfer({c, 1'b1}, q);
    go;
    xfer({ADDR, 2'b11}, q);
    xfer(9'h1fe, q);
    v[7:0] = q[8:1];
    xfer(9'h1ff, q);
    v[15:8] = q[8:1];
    stop;
  endtask : rd
endmodule : mpf_host

// [mpf_monitor_test.sv]
// self-checking bench for the monitor, peak and fault block
`timescale 1ns/1ps
module mpf_monitor_test;
  import mpf_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, nc_f = 1'b0, ot_w = 1'b0, band = 1'b0;
  logic clr = 1'b0, rdef = 1'b0, scl, sda_low, sda_oe, al_oe, store, en;
  logic [15:0] vo = 16'h0, io = 16'h0, hi = 16'hffff, lo = 16'h0, v;
  logic [11:0] dac, d0;
  int bad_count = 0, compares = 0, n;
  wire logic sda = !(sda_low | sda_oe);
  logic [43:0] rows [14] = '{44'h0_d2_0000_000a, 44'h0_d3_0000_0032,
    44'h0_d4_0000_0000, 44'h0_d5_0000_0000, 44'h0_d6_0000_0000,
    44'h0_d7_0000_0000, 44'h0_d9_0000_0000, 44'h1_d4_1234_1234,
    44'h1_d4_0000_0000, 44'h1_d5_0abc_0abc, 44'h1_d6_ffff_8000,
    44'h1_d7_0300_0300, 44'h1_d9_ffff_83ff, 44'h1_d8_5555_0002};
  mpf_host host (.scl(scl), .sda_low(sda_low), .sda(sda));
  mpf_monitor mpf_monitor_inst (.clock(clock), .reset_n(reset_n),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .vout_sample(vo), .iout_sample(io), .temp_sample(16'h0000),
    .vout_high_fault_limit(hi), .vout_high_warning_limit(hi),
    .vout_low_warning_limit(lo), .vout_low_fault_limit(lo),
    .output_overcurrent_warning(nc_f), .output_overcurrent_fault(1'b0),
    .negative_current_fault(nc_f), .overheat_warning(ot_w),
    .overheat_fault(1'b0), .in_regulation_band(band), .trim_raise(1'b1),
    .supply_on_request(1'b1), .clear_faults(clr), .restore_defaults(rdef),
    .reference_dac_output(dac), .supply_enable_output(en),
    .fault_alert_pin_out(), .fault_alert_pin_oe(al_oe),
    .peak_store_req(store));
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic conclude;
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // one-cycle clear request, then read the flags
  task automatic clear_read(input logic [15:0] e);
    @(negedge clock) clr = 1'b1;
    @(negedge clock) clr = 1'b0;
    host.rd(CMD_ALARM_FLAGS, v);
    check(v, e);
  endtask : clear_read
  initial begin
    #3ms bad_count++;
    conclude;
  end
  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    foreach (rows[i]) begin
      if (rows[i][40]) host.wr(rows[i][39:32], rows[i][31:16]);
      host.rd(rows[i][39:32], v);
      check(v, rows[i][15:0]);
    end
    // flags survive a defaults restore
    @(negedge clock) rdef = 1'b1;
    @(negedge clock) rdef = 1'b0;
    host.rd(CMD_ALARM_FLAGS, v);
    check(v, 16'h0002);
    check({15'h0, al_oe}, 16'h0001);
    clear_read(16'h0000);
    // fast monitoring, fault with peak saving
    host.wr(CMD_MONITOR_RATE_DIV, 16'h0001);
    host.wr(CMD_ALARM_ACTION_CONFIG, 16'h8000);
    host.wr(CMD_MAX_CURRENT_SEEN, 16'h0abc);
    nc_f = 1'b1;
    vo = 16'h0200;
    io = 16'h0c00;
    for (n = 0; n < 3000 && store !== 1'b1; n++) @(negedge clock);
    check({15'h0, store}, 16'h0001);
    nc_f = 1'b0;
    host.rd(CMD_ALARM_FLAGS, v);
    check(v, 16'h1801);
    host.rd(CMD_MAX_VOLTAGE_SEEN, v);
    check(v, 16'h0200);
    host.rd(CMD_MAX_CURRENT_SEEN, v);
    check(v, 16'h0c00);
    clear_read(16'h0000);
    ot_w = 1'b1;
    repeat (2600) @(negedge clock);
    ot_w = 1'b0;
    host.rd(CMD_ALARM_FLAGS, v);
    check(v, 16'h4004);
    clear_read(16'h0000);
    host.wr(CMD_MONITOR_RATE_DIV, 16'h0000);
    nc_f = 1'b1;
    repeat (5100) @(negedge clock);
    nc_f = 1'b0;
    host.rd(CMD_ALARM_FLAGS, v);
    check(v, 16'h0000);
    // trim one step per base tick, then stopped
    host.wr(CMD_TRIM_STEP_RATE_DIV, 16'h0001);
    band = 1'b1;
    d0 = dac;
    for (n = 0; n < 3000 && dac === d0; n++) @(negedge clock);
    d0 = dac;
    repeat (2499) @(negedge clock);
    check({4'h0, dac}, {4'h0, d0});
    repeat (2) @(negedge clock);
    check({4'h0, dac}, {4'h0, d0 + 12'h001});
    host.wr(CMD_TRIM_STEP_RATE_DIV, 16'h0000);
    d0 = dac;
    repeat (5100) @(negedge clock);
    check({4'h0, dac}, {4'h0, d0});
    // long averaging run refuses the bus; neg current shuts supply
    host.wr(CMD_ALARM_ACTION_CONFIG, 16'h8100);
    host.wr(CMD_AVERAGING_CONFIG, 16'hff02);
    vo = 16'h0400;
    nc_f = 1'b1;
    host.wr(CMD_MONITOR_RATE_DIV, 16'h0003);
    repeat (7500) @(negedge clock);
    host.wr(CMD_TRIM_STEP_RATE_DIV, 16'h0005);
    for (n = 0; n < 6000 && store !== 1'b1; n++) @(negedge clock);
    nc_f = 1'b0;
    check({15'h0, en}, 16'h0000);
    host.rd(CMD_TRIM_STEP_RATE_DIV, v);
    check(v, 16'h0000);
    host.rd(CMD_ALARM_FLAGS, v);
    check(v, 16'h1841);
    host.rd(CMD_MAX_VOLTAGE_SEEN, v);
    check(v, 16'h0400);
    conclude;
  end
endmodule : mpf_monitor_test
